//--- i2cab_pkg.sv
// constants shared by the transmit abort cause block.
// assumes a 32-bit classic wishbone bus and a 100 MHz system clock.
package i2cab_pkg;

  localparam int unsigned I2CAB_DW = 32;
  localparam int unsigned I2CAB_AW = 32;
  localparam int unsigned I2CAB_RW = 16;
  localparam int unsigned I2CAB_FLW = 6;

  // register byte addresses
  localparam logic [31:0] I2CAB_CFG_ADDR = 32'h5000_1300;
  localparam logic [31:0] I2CAB_TAR_ADDR = 32'h5000_1304;
  localparam logic [31:0] I2CAB_CMD_ADDR = 32'h5000_1310;
  localparam logic [31:0] I2CAB_CLR_ADDR = 32'h5000_1354;
  localparam logic [31:0] I2CAB_SRC_ADDR = 32'h5000_1380;

  // reset values
  localparam logic [15:0] I2CAB_CFG_RST = 16'h0021;
  localparam logic [15:0] I2CAB_TAR_RST = 16'h0000;
  localparam logic [15:0] I2CAB_SRC_RST = 16'h0000;

  // controller_config fields
  localparam int unsigned CFG_MASTER_EN = 0;
  localparam int unsigned CFG_HIGH_SPEED = 2;
  localparam int unsigned CFG_WIDE_ADDR = 4;
  localparam int unsigned CFG_RESTART = 5;

  // target_address_config fields
  localparam int unsigned TAR_GC_OR_SB = 10;
  localparam int unsigned TAR_CMD_SEL = 11;

  // data_command_word fields
  localparam int unsigned CMD_READ = 8;
  localparam int unsigned CMD_GCALL_READ = 9;
  localparam int unsigned CMD_W = 10;

  // abort cause bit positions
  localparam int unsigned AB_NARROW_NACK = 0;
  localparam int unsigned AB_WIDE1_NACK = 1;
  localparam int unsigned AB_WIDE2_NACK = 2;
  localparam int unsigned AB_DATA_NACK = 3;
  localparam int unsigned AB_BCAST_NACK = 4;
  localparam int unsigned AB_BCAST_READ = 5;
  localparam int unsigned AB_FCODE_ACK = 6;
  localparam int unsigned AB_SBYTE_ACK = 7;
  localparam int unsigned AB_FAST_NORS = 8;
  localparam int unsigned AB_SBYTE_NORS = 9;
  localparam int unsigned AB_WIDE_RD_NORS = 10;
  localparam int unsigned AB_MASTER_DIS = 11;
  localparam int unsigned AB_ARB_LOSS = 12;
  localparam int unsigned AB_SLV_FLUSH = 13;
  localparam int unsigned AB_SLV_LOSS = 14;
  localparam int unsigned AB_SLV_RD_CMD = 15;

  // kind of byte whose acknowledge slot the protocol engine reports
  typedef enum logic [2:0] {
    I2CAB_BK_ADDR7,
    I2CAB_BK_ADDR10_1,
    I2CAB_BK_ADDR10_2,
    I2CAB_BK_GCALL,
    I2CAB_BK_SBYTE,
    I2CAB_BK_FCODE,
    I2CAB_BK_DATA
  } i2cab_byte_kind_t;

endpackage

//--- i2cab_abort_cause.sv
// transmit abort cause flags of the i2c controller, with a wishbone slave.
// assumes the protocol engine on the same clock reports byte and acknowledge
// results; scl and sda come straight from the pins and are synchronised here.
//
// Summary of operation
// - slave read answered with read command: flag 15
// - slave loses bus: flags 14 and 12
// - sda mismatch at scl rise means lost bus
// - slave read with stale fifo: flag 13, abort
// - master arbitration loss sets flag 12
// - master start while master disabled: flag 11
// - no restart, wide address read: flag 10
// - no restart, start byte attempt: flag 9
// - unfixed start byte cause reasserts flag 9
// - no restart, high speed transfer: flag 8
// - start byte acknowledged: flag 7
// - high speed code acknowledged: flag 6
// - read after general call: flag 5
// - general call not acknowledged: flag 4
// - master data byte not acknowledged: flag 3
// - second wide address byte unacknowledged: flag 2
// - first wide address byte unacknowledged: flag 1
// - narrow address unacknowledged: flag 0
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

module i2cab_abort_cause
  import i2cab_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [i2cab_pkg::I2CAB_AW-1:0] wb_adr_i,
  input wire logic [i2cab_pkg::I2CAB_DW-1:0] wb_dat_i,
  output logic [i2cab_pkg::I2CAB_DW-1:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic master_tx_active_i,
  input wire logic slave_tx_active_i,
  input wire logic tx_bit_i,
  input wire logic slave_read_req_i,
  input wire logic [i2cab_pkg::I2CAB_FLW-1:0] tx_fifo_level_i,
  input wire logic byte_done_i,
  input wire i2cab_pkg::i2cab_byte_kind_t byte_kind_i,
  input wire logic byte_acked_i,
  input wire logic bus_stop_i,
  output logic cmd_push_o,
  output logic [i2cab_pkg::CMD_W-1:0] cmd_word_o,
  output logic transmit_abort_interrupt_o,
  output logic bus_lost_o
);
  import i2cab_pkg::*;

  // bus slave
  logic ack_q;
  logic [I2CAB_DW-1:0] rdata_q;
  logic req;
  logic wr_go;
  logic rd_go;
  logic half_sel;

  logic [15:0] cfg_q;
  logic [15:0] tar_q;
  logic [15:0] flags_q;
  logic [15:0] set_vec;
  logic clr_go;

  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic scl_rise;
  logic mismatch;

  logic slv_rd_pend_q;
  logic gcall_done_q;
  logic sbyte_latched_q;
  logic sbyte_cause;
  logic cmd_go;
  logic [15:0] wr_word;
  logic cmd_ok;

  assign req = wb_cyc_i & wb_stb_i;
  // side effects only at the edge where the master sees ack
  assign wr_go = req & ack_q & wb_we_i;
  assign rd_go = req & ack_q & ~wb_we_i;
  assign half_sel = wb_sel_i[0] & wb_sel_i[1];
  assign wr_word = wb_dat_i[15:0];
  assign wb_ack_o = ack_q;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data is latched at the same edge that raises ack so it stands with ack
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (req & ~ack_q) begin
      if (hit(wb_adr_i, I2CAB_SRC_ADDR)) begin
        rdata_q <= {16'h0000, flags_q};
      end else if (hit(wb_adr_i, I2CAB_CFG_ADDR)) begin
        rdata_q <= {16'h0000, cfg_q};
      end else if (hit(wb_adr_i, I2CAB_TAR_ADDR)) begin
        rdata_q <= {16'h0000, tar_q};
      end else begin
        rdata_q <= '0;
      end
    end
  end
  assign wb_dat_o = rdata_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_q <= I2CAB_CFG_RST;
    end else if (wr_go && half_sel && hit(wb_adr_i, I2CAB_CFG_ADDR)) begin
      cfg_q <= wr_word;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tar_q <= I2CAB_TAR_RST;
    end else if (wr_go && half_sel && hit(wb_adr_i, I2CAB_TAR_ADDR)) begin
      tar_q <= wr_word;
    end
  end

  assign cmd_go = wr_go & half_sel & hit(wb_adr_i, I2CAB_CMD_ADDR);
  // reading the clear register drops flag 9 and every other flag that is not raised again in the same cycle
  assign clr_go = rd_go & hit(wb_adr_i, I2CAB_CLR_ADDR);

  // a command that raises an abort is not handed on
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cmd_push_o <= 1'b0;
      cmd_word_o <= '0;
    end else begin
      cmd_push_o <= cmd_go & cmd_ok;
      if (cmd_go) begin
        cmd_word_o <= wr_word[CMD_W-1:0];
      end
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  // a released one read back as zero means another driver won
  assign mismatch = scl_rise & (sda_s_q != tx_bit_i) &
                    (master_tx_active_i | slave_tx_active_i);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_lost_o <= 1'b0;
    end else begin
      bus_lost_o <= mismatch;
    end
  end

  // outstanding slave read request, answered by the next command write
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      slv_rd_pend_q <= 1'b0;
    end else if (slave_read_req_i) begin
      slv_rd_pend_q <= 1'b1;
    end else if (cmd_go | bus_stop_i) begin
      slv_rd_pend_q <= 1'b0;
    end
  end

  // general call sent and acknowledged, until stop
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gcall_done_q <= 1'b0;
    end else if (byte_done_i && byte_kind_i == I2CAB_BK_GCALL &&
                 byte_acked_i) begin
      gcall_done_q <= 1'b1;
    end else if (bus_stop_i) begin
      gcall_done_q <= 1'b0;
    end
  end

  assign sbyte_cause = ~cfg_q[CFG_RESTART] & tar_q[TAR_CMD_SEL] &
                       tar_q[TAR_GC_OR_SB];

  // start byte abort stays armed while its cause is left in place
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sbyte_latched_q <= 1'b0;
    end else if (!sbyte_cause) begin
      sbyte_latched_q <= 1'b0;
    end else if (cmd_go) begin
      sbyte_latched_q <= 1'b1;
    end
  end

  always_comb begin
    set_vec = '0;
    // software side causes, judged at the command write
    if (cmd_go) begin
      set_vec[AB_SLV_RD_CMD] = slv_rd_pend_q & wr_word[CMD_READ];
      set_vec[AB_MASTER_DIS] = ~slv_rd_pend_q &
                               ~cfg_q[CFG_MASTER_EN];
      set_vec[AB_WIDE_RD_NORS] = ~cfg_q[CFG_RESTART] &
                                 cfg_q[CFG_WIDE_ADDR] &
                                 wr_word[CMD_READ];
      set_vec[AB_SBYTE_NORS] = sbyte_cause;
      set_vec[AB_FAST_NORS] = ~cfg_q[CFG_RESTART] &
                              cfg_q[CFG_HIGH_SPEED];
      set_vec[AB_BCAST_READ] = gcall_done_q &
                               wr_word[CMD_GCALL_READ];
    end
    if (sbyte_latched_q) begin
      set_vec[AB_SBYTE_NORS] = 1'b1;
    end
    // stale data left when a remote master asks to read
    if (slave_read_req_i && tx_fifo_level_i != '0) begin
      set_vec[AB_SLV_FLUSH] = 1'b1;
    end
    // lost bus, with both roles possibly active at once
    if (mismatch) begin
      set_vec[AB_ARB_LOSS] = 1'b1;
      set_vec[AB_SLV_LOSS] = slave_tx_active_i;
    end
    // acknowledge slot results from the master engine
    if (byte_done_i && master_tx_active_i) begin
      case (byte_kind_i)
        I2CAB_BK_ADDR7: begin
          set_vec[AB_NARROW_NACK] = ~byte_acked_i;
        end
        I2CAB_BK_ADDR10_1: begin
          set_vec[AB_WIDE1_NACK] = ~byte_acked_i;
        end
        I2CAB_BK_ADDR10_2: begin
          set_vec[AB_WIDE2_NACK] = ~byte_acked_i;
        end
        I2CAB_BK_GCALL: begin
          set_vec[AB_BCAST_NACK] = ~byte_acked_i;
        end
        I2CAB_BK_SBYTE: begin
          set_vec[AB_SBYTE_ACK] = byte_acked_i;
        end
        I2CAB_BK_FCODE: begin
          set_vec[AB_FCODE_ACK] = byte_acked_i &
                                  cfg_q[CFG_HIGH_SPEED];
        end
        I2CAB_BK_DATA: begin
          set_vec[AB_DATA_NACK] = ~byte_acked_i;
        end
        default: begin
          set_vec[AB_NARROW_NACK] = 1'b0;
        end
      endcase
    end
  end

  // a command is forwarded only if it raises no software side cause
  always_comb begin
    cmd_ok = 1'b1;
    if (cmd_go) begin
      cmd_ok = ~(set_vec[AB_SLV_RD_CMD] | set_vec[AB_MASTER_DIS] |
                   set_vec[AB_WIDE_RD_NORS] | set_vec[AB_SBYTE_NORS] |
                   set_vec[AB_FAST_NORS] | set_vec[AB_BCAST_READ]);
    end
  end

  // sticky flags: a new event beats a clear, except that flag 9
  // drops for the clearing cycle so software sees the cause return
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_q <= I2CAB_SRC_RST;
    end else if (clr_go) begin
      flags_q <= set_vec & ~(16'h0001 << AB_SBYTE_NORS);
    end else begin
      flags_q <= flags_q | set_vec;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      transmit_abort_interrupt_o <= 1'b0;
    end else begin
      transmit_abort_interrupt_o <= |(flags_q | set_vec);
    end
  end

  // checks
  slave_loss_pair_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    mismatch && slave_tx_active_i
    |=> flags_q[AB_SLV_LOSS] && flags_q[AB_ARB_LOSS])
    else $error("slave bus loss did not set flags 14 and 12");

  pin_mismatch_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    $rose(scl_s_q) && master_tx_active_i && sda_s_q != tx_bit_i
    |=> bus_lost_o && flags_q[AB_ARB_LOSS])
    else $error("data line mismatch not seen as bus loss");

  stale_flush_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    slave_read_req_i && tx_fifo_level_i != 0
    |=> flags_q[AB_SLV_FLUSH] ##1 transmit_abort_interrupt_o)
    else $error("stale fifo read did not abort");

  slave_rd_cmd_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    cmd_go && slv_rd_pend_q && wr_word[CMD_READ]
    |=> flags_q[AB_SLV_RD_CMD] && !cmd_push_o)
    else $error("read command answering a slave read not flagged");

  master_off_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    cmd_go && !cfg_q[CFG_MASTER_EN] && !slv_rd_pend_q
    |=> flags_q[AB_MASTER_DIS] && !cmd_push_o)
    else $error("command with master off not flagged");

  sbyte_reassert_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    clr_go && sbyte_latched_q && sbyte_cause
    |=> !flags_q[AB_SBYTE_NORS] ##1 flags_q[AB_SBYTE_NORS])
    else $error("start byte flag did not clear once and return");

  narrow_nack_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    byte_done_i && master_tx_active_i && byte_kind_i == I2CAB_BK_ADDR7
    && !byte_acked_i |=> flags_q[AB_NARROW_NACK])
    else $error("narrow address nack not flagged");

  data_nack_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    byte_done_i && !master_tx_active_i |=> $stable(flags_q[AB_DATA_NACK])
    || clr_go || $past(clr_go))
    else $error("data nack flag moved outside master mode");

  sticky_flags_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    !clr_go |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("abort flag dropped without a clear");

  bus_ack_a: assert property (@(posedge clock_i)
    disable iff (sys_rst_i)
    req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");

endmodule

`default_nettype wire

//--- i2cab_bus_model.sv
// remote party on the serial side: drives scl and sda as pin levels.
// assumes pull-ups on both lines; scl stands high outside frames.
`timescale 1ns/1ns
`default_nettype none

module i2cab_bus_model (
  input wire logic frame_i,
  input wire logic sda_drive_i,
  output logic scl_o,
  output logic sda_o
);
  initial scl_o = 1'b1;
  // 160 ns link period, toggling on falling edges of the system clock
  always #80 scl_o = frame_i ? ~scl_o : 1'b1;
  // released line floats to the pull-up level
  assign sda_o = frame_i ? sda_drive_i : 1'b1;
endmodule

`default_nettype wire

//--- i2cab_abort_cause_bench.sv
// bench for the transmit abort cause block: wishbone tasks and scenarios.
// assumes the bus model stands in for remote masters and slaves.
`timescale 1ns/1ns
`default_nettype none

module i2cab_abort_cause_bench;
  import i2cab_pkg::*;
  logic clock_i = 0, sys_rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, dat = 0, rdat, q;
  logic [3:0] sel = 4'hf;
  logic mtx = 0, stx = 0, txb = 0, srr = 0, bdone = 0, backed = 0;
  logic bstop = 0, frame = 0, sdrv = 1, scl, sda, push, irq, lost;
  logic [5:0] lvl = 0;
  logic [9:0] cw;
  logic ack;
  i2cab_byte_kind_t kind = I2CAB_BK_ADDR7;
  int failures = 0, n_checks = 0;
  i2cab_byte_kind_t kinds[7] = '{I2CAB_BK_ADDR7, I2CAB_BK_ADDR10_1,
    I2CAB_BK_ADDR10_2, I2CAB_BK_GCALL, I2CAB_BK_DATA, I2CAB_BK_SBYTE,
    I2CAB_BK_FCODE};
  logic acks[7] = '{0, 0, 0, 0, 0, 1, 1};
  int pos[7] = '{0, 1, 2, 4, 3, 7, 6};

  always #5 clock_i = ~clock_i;

  i2cab_bus_model i2cab_bus_model_i (.frame_i(frame), .sda_drive_i(sdrv),
    .scl_o(scl), .sda_o(sda));
  i2cab_abort_cause i2cab_abort_cause_i (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .scl_i(scl), .sda_i(sda), .master_tx_active_i(mtx),
    .slave_tx_active_i(stx), .tx_bit_i(txb), .slave_read_req_i(srr),
    .tx_fifo_level_i(lvl), .byte_done_i(bdone), .byte_kind_i(kind),
    .byte_acked_i(backed), .bus_stop_i(bstop), .cmd_push_o(push),
    .cmd_word_o(cw), .transmit_abort_interrupt_o(irq), .bus_lost_o(lost));

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // request held until ack is sampled high; no fixed latency assumed
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    if (ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask

  // reads the cause register, compares, then clears through the clear read
  task automatic src_is(input logic [31:0] e);
    wb(0, I2CAB_SRC_ADDR, 0);
    chk("cause", q, e);
    wb(0, I2CAB_CLR_ADDR, 0);
  endtask

  task automatic done(input i2cab_byte_kind_t k, input logic a);
    @(posedge clock_i);
    kind <= k; backed <= a; bdone <= 1;
    @(posedge clock_i);
    bdone <= 0;
  endtask

  task automatic pulse_stop();
    @(posedge clock_i);
    bstop <= 1;
    @(posedge clock_i);
    bstop <= 0;
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 0;
    wb(0, I2CAB_CFG_ADDR, 0);
    chk("config", q, 32'h0000_0021);
    wb(0, 32'h5000_13f0, 0);
    chk("unmapped", q, 32'h0000_0000);
    src_is(32'h0000_0000);
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0025);
    mtx <= 1;
    foreach (kinds[i]) begin
      done(I2CAB_BK_ADDR7, 1);
      done(kinds[i], acks[i]);
      wb(1, I2CAB_SRC_ADDR, 32'h0000_0000);
      wb(0, I2CAB_SRC_ADDR, 0);
      chk("sticky", q, 32'h0000_0001 << pos[i]);
      src_is(32'h1 << pos[i]);
      // the interrupt level trails the clear by one cycle
      repeat (2) @(posedge clock_i);
      chk("irq", irq, 0);
      pulse_stop();
    end
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0021);
    // a command that raises no cause is handed on
    wb(1, I2CAB_CMD_ADDR, 32'h0000_00ab);
    @(posedge clock_i);
    chk("push", push, 1);
    chk("word", cw, 32'h0000_00ab);
    done(I2CAB_BK_GCALL, 1);
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0200);
    src_is(32'h0000_0020);
    pulse_stop();
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0020);
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0000);
    @(posedge clock_i);
    chk("push", push, 0);
    src_is(32'h0000_0800);
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0011);
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0100);
    src_is(32'h0000_0400);
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0001);
    wb(1, I2CAB_TAR_ADDR, 32'h0000_0c00);
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0000);
    src_is(32'h0000_0200);
    // cause still present: the flag returns after the clear
    src_is(32'h0000_0200);
    wb(1, I2CAB_TAR_ADDR, 32'h0000_0000);
    wb(0, I2CAB_CLR_ADDR, 0);
    src_is(32'h0000_0000);
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0005);
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0000);
    src_is(32'h0000_0100);
    wb(1, I2CAB_CFG_ADDR, 32'h0000_0021);
    mtx <= 0;
    // an unacknowledged data byte outside master mode must not flag
    done(I2CAB_BK_DATA, 0);
    @(posedge clock_i);
    srr <= 1;
    @(posedge clock_i);
    srr <= 0;
    wb(1, I2CAB_CMD_ADDR, 32'h0000_0100);
    src_is(32'h0000_8000);
    pulse_stop();
    lvl <= 6'd3;
    @(posedge clock_i);
    srr <= 1;
    @(posedge clock_i);
    srr <= 0;
    repeat (2) @(posedge clock_i);
    chk("abort irq", irq, 1);
    src_is(32'h0000_2000);
    pulse_stop();
    lvl <= 0;
    for (int r = 0; r < 2; r++) begin
      stx <= (r == 0);
      mtx <= (r == 1);
      txb <= 0;
      sdrv <= 1;
      frame <= 1;
      for (int n = 0; n <= 100; n++) begin
        @(posedge clock_i);
        if (lost === 1'b1) break;
        if (n == 100) begin
          failures++;
          report_and_stop();
        end
      end
      frame <= 0;
      stx <= 0;
      mtx <= 0;
      repeat (40) @(posedge clock_i);
      src_is(r == 0 ? 32'h0000_5000 : 32'h0000_1000);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
